// file: verilog/slsp_pkg.sv
// ***************************************************************
// streaming source port shared constants and types
// ***************************************************************
package slsp_pkg;

  // clock rate and reset sequence timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned RESET_SEQ_NS   = 1000;
  // least time, so round up to whole cycles
  localparam int unsigned RESET_SEQ_CYC  =
    (RESET_SEQ_NS * CLK_MHZ + 999) / 1000;

  // lane and side-band geometry
  localparam int unsigned LANE_BITS      = 64;
  localparam int unsigned TAG_W          = 8;
  localparam int unsigned ERR_W          = 4;

  // register byte addresses
  localparam logic [7:0]  ADR_CTRL       = 8'h00;
  localparam logic [7:0]  ADR_GAP        = 8'h04;
  localparam logic [7:0]  ADR_DRAIN      = 8'h08;
  localparam logic [7:0]  ADR_STATUS     = 8'h0C;

  // control register bit positions
  localparam int unsigned CTRL_ADV       = 0;
  localparam int unsigned CTRL_BURST     = 1;
  localparam int unsigned CTRL_ECC       = 2;
  localparam int unsigned CTRL_CRC       = 3;
  localparam int unsigned CTRL_W         = 4;

  // error vector bit positions
  localparam int unsigned ERR_OVF        = 0;
  localparam int unsigned ERR_SEU_FIX    = 1;
  localparam int unsigned ERR_SEU_BAD    = 2;
  localparam int unsigned ERR_GAP        = 3;

  // status register field positions
  localparam int unsigned STAT_LINK      = 0;
  localparam int unsigned STAT_CLR       = 1;
  localparam int unsigned STAT_CNT_LSB   = 8;
  localparam int unsigned STAT_ERR_LSB   = 16;

  // values after reset
  localparam logic [3:0]  CTRL_RST       = 4'h2;
  localparam logic [7:0]  GAP_RST        = 8'h02;
  localparam logic [7:0]  DRAIN_RST      = 8'h01;

  // reset sequencer states
  typedef enum logic [2:0] {
    RS_HOLD = 3'b001,
    RS_INIT = 3'b010,
    RS_RUN  = 3'b100
  } slsp_rst_e;

  // classic wishbone request and answer
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } slsp_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } slsp_wb_rsp_s;

  // side-band qualifiers of one user beat
  typedef struct packed {
    logic             valid;
    logic             first;
    logic             last;
    logic [TAG_W-1:0] tag;
  } slsp_beat_s;

  // side-band of one word sent towards the lanes
  typedef struct packed {
    logic             valid;
    logic             first;
    logic             last;
    logic [TAG_W-1:0] tag;
    logic             crc_bad;
  } slsp_tx_s;

endpackage

// file: verilog/slsp_store.sv
`timescale 1ns/1ns
// ***************************************************************
// adaptation buffer storage, registered read port
// ***************************************************************
module slsp_store #(
  parameter int unsigned W     = 16,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);

  logic [W-1:0] mem [DEPTH];

  // no reset on the array: contents are only read after being written
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // slsp_store

// file: verilog/slsp_source_port.sv
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
module slsp_source_port #(
  parameter int unsigned LANES      = 1,
  parameter int unsigned FIFO_DEPTH = 16,
  parameter int unsigned AW         = $clog2(FIFO_DEPTH)
) (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           mgmt_clr,
  input  wire logic                           beat_clk_in,
  output logic                                beat_clk_out,
  output logic                                beat_clk_oe,
  input  wire logic                           if_clear_in,
  output logic                                if_clear_out,
  output logic                                if_clear_oe,
  output logic                                link_ready,
  input  wire logic [LANES*64-1:0]            data_in,
  input  wire slsp_pkg::slsp_beat_s           beat_ctl,
  input  wire logic                           crc_force,
  output logic      [slsp_pkg::ERR_W-1:0]     err_vec,
  output logic      [LANES*64-1:0]            tx_data,
  output slsp_pkg::slsp_tx_s                  tx_ctl,
  input  wire slsp_pkg::slsp_wb_req_s         wb_req,
  output slsp_pkg::slsp_wb_rsp_s              wb_rsp
);

  localparam int unsigned DW = LANES * slsp_pkg::LANE_BITS;
  localparam int unsigned EW = DW + 2 + slsp_pkg::TAG_W;
  localparam int unsigned MW = 2 * (EW + 1);
  localparam int unsigned TW = slsp_pkg::TAG_W;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(FIFO_DEPTH);
  localparam logic [15:0] SEQ_LAST =
    16'(slsp_pkg::RESET_SEQ_CYC - 1);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [slsp_pkg::CTRL_W-1:0] ctrl;
    logic [7:0]                  gap;
    logic [7:0]                  drain;
    logic                        ack;
    logic [31:0]                 rdat;
    slsp_pkg::slsp_rst_e         rs;
    logic [15:0]                 rs_cnt;
    logic                        clr_out;
    logic [2:0]                  bclk_sy;
    logic                        bclk_lvl;
    logic [2:0]                  clr_sy;
    logic                        clr_lvl;
    logic [AW-1:0]               wa;
    logic [AW-1:0]               ra;
    logic [AW:0]                 cnt;
    logic [7:0]                  tick;
    logic                        rd_pend;
    logic                        gap_run;
    logic [7:0]                  gap_cnt;
    logic [TW-1:0]               tag_first;
    logic [TW-1:0]               tag_last;
    logic                        crc_pend;
    logic [slsp_pkg::ERR_W-1:0]  err_pend;
    logic [slsp_pkg::ERR_W-1:0]  err;
    logic [DW-1:0]               tx_data;
    slsp_pkg::slsp_tx_s          tx;
  } slsp_state_s;

  slsp_state_s s_reg;
  slsp_state_s s_next;
  logic        arst;
  logic        pll_div_reg;
  logic        adv;
  logic        beat_en;
  logic        clr_fifo;
  logic        wr_en;
  logic        rd_en;
  logic        full;
  logic [EW-1:0] wr_entry;
  logic [MW-1:0] mem_rd;
  logic [slsp_pkg::ERR_W-1:0] ev;

  // even parity good when the stored word plus its bit has no odd ones
  function automatic logic par_ok(input logic [EW:0] x);
    par_ok = ~(^x);
  endfunction

  // either clear takes the state registers down at once, without the clock
  assign arst = rst | mgmt_clr;

  // ***************************************************************
  // beat clock generation
  // ***************************************************************
  // the divider stands for the pll, so only the management clear resets it, not rst
  always_ff @(posedge clk or posedge mgmt_clr) begin
    if (mgmt_clr) begin
      pll_div_reg <= 1'b0;
    end else begin
      pll_div_reg <= ~pll_div_reg;
    end
  end

  assign adv          = s_reg.ctrl[slsp_pkg::CTRL_ADV];
  // the pin is only driven by us in standard mode
  assign beat_clk_out = pll_div_reg;
  assign beat_clk_oe  = ~adv;
  assign if_clear_out = s_reg.clr_out;
  assign if_clear_oe  = ~adv;
  // a beat is the rising edge of whichever clock owns the interface
  assign beat_en = adv ? (s_reg.bclk_sy[1] == s_reg.bclk_sy[2]
                          && s_reg.bclk_sy[2] && !s_reg.bclk_lvl)
                       : ~pll_div_reg;

  assign link_ready = s_reg.rs == slsp_pkg::RS_RUN
                      && !(adv && s_reg.clr_lvl);
  assign clr_fifo   = adv && s_reg.clr_lvl;
  assign full       = s_reg.cnt == FULL_CNT;
  assign rd_en      = s_reg.tick >= s_reg.drain && s_reg.cnt != '0
                      && !clr_fifo;
  assign wr_en      = beat_en && beat_ctl.valid && link_ready
                      && (!full || rd_en) && !clr_fifo;
  // tag only carries meaning on the delimiting beats
  assign wr_entry   = {beat_ctl.first, beat_ctl.last,
                       (beat_ctl.first || beat_ctl.last)
                         ? beat_ctl.tag : {TW{1'b0}},
                       data_in};

  // two parity-guarded copies let one bad copy be outvoted
  slsp_store #(
    .W     (MW),
    .DEPTH (FIFO_DEPTH),
    .AW    (AW)
  ) u_store (
    .clk     (clk),
    .wr_en   (wr_en),
    .wr_addr (s_reg.wa),
    .wr_data ({2{^wr_entry, wr_entry}}),
    .rd_en   (rd_en),
    .rd_addr (s_reg.ra),
    .rd_data (mem_rd)
  );

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    logic [EW:0]   ca;
    logic [EW:0]   cb;
    logic [EW-1:0] pick;
    logic          wb_go;
    ca    = mem_rd[MW-1 -: EW+1];
    cb    = mem_rd[EW:0];
    pick  = ca[EW-1:0];
    wb_go = wb_req.cyc && wb_req.stb;
    s_next = s_reg;
    ev = '0;

    // wishbone slave: answer one cycle after the strobe, any address
    s_next.ack = wb_go && !s_reg.ack;
    if (wb_go && !s_reg.ack) begin
      case (wb_req.adr)
        slsp_pkg::ADR_CTRL:   s_next.rdat = 32'(s_reg.ctrl);
        slsp_pkg::ADR_GAP:    s_next.rdat = 32'(s_reg.gap);
        slsp_pkg::ADR_DRAIN:  s_next.rdat = 32'(s_reg.drain);
        slsp_pkg::ADR_STATUS: begin
          s_next.rdat = '0;
          s_next.rdat[slsp_pkg::STAT_LINK] = link_ready;
          s_next.rdat[slsp_pkg::STAT_CLR]  = s_reg.clr_out;
          s_next.rdat[slsp_pkg::STAT_CNT_LSB +: AW+1] = s_reg.cnt;
          s_next.rdat[slsp_pkg::STAT_ERR_LSB +: slsp_pkg::ERR_W] =
            s_reg.err;
        end
        default:              s_next.rdat = '0;
      endcase
    end
    // the write lands on the edge where the master sees ack
    if (s_reg.ack && wb_req.we && wb_req.sel[0]) begin
      case (wb_req.adr)
        slsp_pkg::ADR_CTRL:  s_next.ctrl  =
          wb_req.dat[slsp_pkg::CTRL_W-1:0];
        slsp_pkg::ADR_GAP:   s_next.gap   = wb_req.dat[7:0];
        slsp_pkg::ADR_DRAIN: s_next.drain = wb_req.dat[7:0];
        default: begin
        end
      endcase
    end

    // reset sequencer holds the domain clear until the core settles
    case (s_reg.rs)
      slsp_pkg::RS_HOLD: begin
        s_next.rs     = slsp_pkg::RS_INIT;
        s_next.rs_cnt = '0;
      end
      slsp_pkg::RS_INIT: begin
        s_next.rs_cnt = s_reg.rs_cnt + 16'h0001;
        if (s_reg.rs_cnt >= SEQ_LAST) begin
          s_next.rs      = slsp_pkg::RS_RUN;
          s_next.clr_out = 1'b0;
        end
      end
      slsp_pkg::RS_RUN: begin
        s_next.clr_out = 1'b0;
      end
      default: begin
        s_next.rs      = slsp_pkg::RS_HOLD;
        s_next.clr_out = 1'b1;
      end
    endcase

    // pin synchronisers; a level counts once stages two and three agree
    s_next.bclk_sy = {s_reg.bclk_sy[1:0], beat_clk_in};
    s_next.clr_sy  = {s_reg.clr_sy[1:0], if_clear_in};
    if (s_reg.bclk_sy[1] == s_reg.bclk_sy[2]) begin
      s_next.bclk_lvl = s_reg.bclk_sy[2];
    end
    if (s_reg.clr_sy[1] == s_reg.clr_sy[2]) begin
      s_next.clr_lvl = s_reg.clr_sy[2];
    end

    // adaptation buffer pointers and fill count
    if (wr_en) begin
      s_next.wa = s_reg.wa + AW'(1);
    end
    if (rd_en) begin
      s_next.ra = s_reg.ra + AW'(1);
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(wr_en) - (AW+1)'(rd_en);
    s_next.tick = rd_en ? 8'h00
                : (s_reg.tick == 8'hFF ? s_reg.tick
                                       : s_reg.tick + 8'h01);
    s_next.rd_pend = rd_en;
    if (clr_fifo) begin
      s_next.wa      = '0;
      s_next.ra      = '0;
      s_next.cnt     = '0;
      s_next.rd_pend = 1'b0;
    end
    // a beat that finds no room is dropped and reported
    if (beat_en && beat_ctl.valid && link_ready && full && !rd_en) begin
      ev[slsp_pkg::ERR_OVF] = 1'b1;
    end

    // delimiting beats capture the tag for the far end
    if (wr_en && beat_ctl.first) begin
      s_next.tag_first = beat_ctl.tag;
    end
    if (wr_en && beat_ctl.last) begin
      s_next.tag_last = beat_ctl.tag;
    end

    // gap check only means something between bursts in burst mode
    if (beat_en && link_ready && s_reg.ctrl[slsp_pkg::CTRL_BURST]) begin
      if (beat_ctl.valid && beat_ctl.first) begin
        if (s_reg.gap_run && s_reg.gap_cnt != s_reg.gap) begin
          ev[slsp_pkg::ERR_GAP] = 1'b1;
        end
        s_next.gap_run = 1'b0;
      end else if (s_reg.gap_run && s_reg.gap_cnt != 8'hFF) begin
        s_next.gap_cnt = s_reg.gap_cnt + 8'h01;
      end
      if (beat_ctl.valid && beat_ctl.last) begin
        s_next.gap_run = 1'b1;
        s_next.gap_cnt = 8'h00;
      end
    end

    // fault force waits for the next outgoing word
    if (beat_en && crc_force && s_reg.ctrl[slsp_pkg::CTRL_CRC]) begin
      s_next.crc_pend = 1'b1;
    end

    // read side: vote between copies, then present the word
    s_next.tx.valid = 1'b0;
    if (s_reg.rd_pend) begin
      if (s_reg.ctrl[slsp_pkg::CTRL_ECC] && (ca != cb || !par_ok(ca))) begin
        if (par_ok(ca)) begin
          ev[slsp_pkg::ERR_SEU_FIX] = 1'b1;
        end else if (par_ok(cb)) begin
          pick = cb[EW-1:0];
          ev[slsp_pkg::ERR_SEU_FIX] = 1'b1;
        end else begin
          ev[slsp_pkg::ERR_SEU_BAD] = 1'b1;
        end
      end
      s_next.tx_data    = pick[DW-1:0];
      s_next.tx.valid   = 1'b1;
      s_next.tx.first   = pick[EW-1];
      s_next.tx.last    = pick[EW-2];
      s_next.tx.tag     = pick[EW-3 -: TW];
      s_next.tx.crc_bad = s_reg.crc_pend || s_next.crc_pend;
      s_next.crc_pend   = 1'b0;
    end

    // events gather between beats and show for one whole beat;
    // a fresh event on a beat goes straight to the vector; the pending set still clears
    if (beat_en) begin
      s_next.err      = s_reg.err_pend | ev;
      s_next.err_pend = '0;
    end else begin
      s_next.err_pend = s_reg.err_pend | ev;
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      s_reg         <= '0;
      s_reg.ctrl    <= slsp_pkg::CTRL_RST;
      s_reg.gap     <= slsp_pkg::GAP_RST;
      s_reg.drain   <= slsp_pkg::DRAIN_RST;
      s_reg.rs      <= slsp_pkg::RS_HOLD;
      s_reg.clr_out <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign err_vec = s_reg.err;
  assign tx_data = s_reg.tx_data;
  assign tx_ctl  = s_reg.tx;
  assign wb_rsp  = '{ack: s_reg.ack, dat: s_reg.rdat};

  // copies seen by the upset check, same split as the read side
  logic [EW:0] ca_w;
  logic [EW:0] cb_w;
  assign ca_w = mem_rd[MW-1 -: EW+1];
  assign cb_w = mem_rd[EW:0];

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb_main @(posedge clk); endclocking
  default disable iff (arst);

  link_after_init_a: assert property (
    link_ready |-> s_reg.rs == slsp_pkg::RS_RUN && !s_reg.clr_out)
    else $error("link ready before initialization finished");

  clear_until_run_a: assert property (
    s_reg.rs != slsp_pkg::RS_RUN |-> if_clear_out)
    else $error("domain clear released before sequence end");

  err_beat_sync_a: assert property (
    !beat_en |=> $stable(err_vec))
    else $error("error vector moved between beats");

  overflow_flag_a: assert property (
    beat_en && beat_ctl.valid && link_ready && full && !rd_en
    |=> s_reg.err[slsp_pkg::ERR_OVF])
    else $error("overflow not reported");

  gap_mismatch_a: assert property (
    beat_en && link_ready && s_reg.ctrl[slsp_pkg::CTRL_BURST]
    && beat_ctl.valid && beat_ctl.first && s_reg.gap_run
    && s_reg.gap_cnt != s_reg.gap
    |=> s_reg.err[slsp_pkg::ERR_GAP] || s_reg.err_pend[slsp_pkg::ERR_GAP])
    else $error("burst gap mismatch not flagged");

  tag_first_a: assert property (
    wr_en && beat_ctl.first |=> s_reg.tag_first == $past(beat_ctl.tag))
    else $error("first beat tag not captured");

  seu_bad_a: assert property (
    s_reg.rd_pend && s_reg.ctrl[slsp_pkg::CTRL_ECC]
    && !par_ok(ca_w) && !par_ok(cb_w)
    |=> s_reg.err[slsp_pkg::ERR_SEU_BAD]
        || s_reg.err_pend[slsp_pkg::ERR_SEU_BAD])
    else $error("uncorrectable upset not flagged");

  beat_clk_drive_a: assert property (
    !adv && $past(!adv) && !$past(mgmt_clr) |-> beat_clk_oe
    && beat_clk_out != $past(beat_clk_out))
    else $error("beat clock not driven in standard mode");

  fifo_fill_a: assert property (
    wr_en && !rd_en && !clr_fifo |=> s_reg.cnt == $past(s_reg.cnt) + 1)
    else $error("accepted beat not stored");

  crc_gate_a: assert property (
    beat_en && crc_force && !s_reg.ctrl[slsp_pkg::CTRL_CRC]
    && !s_reg.crc_pend |=> !s_reg.crc_pend)
    else $error("checksum fault armed while injection disabled");

endmodule // slsp_source_port

// file: verification/slsp_user_model.sv
`timescale 1ns/1ns
// ***************************************************************
// user streaming logic feeding the source port
// ***************************************************************
module slsp_user_model #(
  parameter int unsigned LANES = 1
) (
  input  wire logic            clk,
  input  wire logic            bclk,
  output logic [LANES*64-1:0]  data_in,
  output slsp_pkg::slsp_beat_s beat_ctl
);
  // quiet pins at time zero
  initial begin
    data_in  = '0;
    beat_ctl = '0;
  end

  // one beat, launched after a take edge and held until the next one
  task automatic put(input logic v, f, l, input logic [7:0] t);
    @(posedge clk iff !bclk);
    beat_ctl <= '{valid: v, first: f, last: l, tag: t};
    // idle data keeps moving so a stale word never looks valid
    data_in  <= v ? {LANES*2{$urandom()}} : ~data_in;
  endtask

  // k bursts of n beats, each followed by g idle beats
  task automatic stream(input int k, n, g);
    for (int b = 0; b < k; b++) begin
      for (int i = 0; i < n; i++)
        put(1'b1, i == 0, i == n - 1,
            (i == n - 1) ? 8'h00 : 8'($urandom()));
      for (int i = 0; i < g; i++)
        put(1'b0, 1'b0, 1'b0, 8'h00);
    end
  endtask
endmodule // slsp_user_model

// file: verification/slsp_source_port_bench.sv
`timescale 1ns/1ns
// ***************************************************************
// source port bench: queue model of the beat path
// ***************************************************************
module slsp_source_port_bench;
  logic                   clk       = 1'b0;
  logic                   rst       = 1'b1;
  logic                   crc_force = 1'b0;
  logic                   chk_on    = 1'b1;
  logic                   clr_in    = 1'b0;
  logic [63:0]            data_in;
  logic [63:0]            tx_data;
  slsp_pkg::slsp_beat_s   beat_ctl;
  slsp_pkg::slsp_tx_s     tx_ctl;
  slsp_pkg::slsp_wb_req_s wb_req    = '0;
  slsp_pkg::slsp_wb_rsp_s wb_rsp;
  logic [3:0]             err_vec;
  logic [3:0]             err_prev  = '0;
  logic                   bclk, bclk_oe, clr_out, link_ready;
  logic [74:0]            exp_q[$];
  logic [31:0]            rd;
  logic [7:0]             adr_t[4]  = '{slsp_pkg::ADR_CTRL,
    slsp_pkg::ADR_GAP, slsp_pkg::ADR_DRAIN, 8'h10};
  logic [31:0]            val_t[4]  = '{32'(slsp_pkg::CTRL_RST),
    32'(slsp_pkg::GAP_RST), 32'(slsp_pkg::DRAIN_RST), 32'h0};
  int                     rises[4]  = '{0, 0, 0, 0};
  int                     fails = 0, checks_done = 0, crc_seen = 0, n, s;

  always #5 clk = ~clk;

  slsp_source_port slsp_source_port_i (
    .clk(clk), .rst(rst), .beat_clk_in(1'b0),
    .mgmt_clr(rst), // one clear for core and divider
    .beat_clk_out(bclk), .beat_clk_oe(bclk_oe), .if_clear_in(clr_in),
    .if_clear_out(clr_out), .if_clear_oe(), .link_ready(link_ready),
    .data_in(data_in), .beat_ctl(beat_ctl), .crc_force(crc_force),
    .err_vec(err_vec), .tx_data(tx_data), .tx_ctl(tx_ctl),
    .wb_req(wb_req), .wb_rsp(wb_rsp));

  slsp_user_model slsp_user_model_i (
    .clk(clk), .bclk(bclk), .data_in(data_in), .beat_ctl(beat_ctl));

  task automatic chk(input logic [74:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    @(posedge clk);
    // no limit of its own: only the watchdog ends a wait for ack
    while (wb_rsp.ack !== 1'b1) begin
      @(posedge clk);
    end
    q = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk);
  endtask

  // model: words taken at take edges must leave in order, tag masked
  always @(posedge clk) begin
    if (!bclk && link_ready && beat_ctl.valid && chk_on)
      exp_q.push_back({data_in, beat_ctl.first, beat_ctl.last,
        (beat_ctl.first | beat_ctl.last) ? beat_ctl.tag : 8'h00});
    if (tx_ctl.valid === 1'b1) begin
      crc_seen += tx_ctl.crc_bad;
      if (chk_on)
        chk({tx_data, tx_ctl.first, tx_ctl.last, tx_ctl.tag},
            exp_q.size() ? exp_q.pop_front() : 'x);
    end
    for (int b = 0; b < 4; b++)
      if (err_vec[b] === 1'b1 && !err_prev[b]) rises[b]++;
    err_prev <= err_vec;
  end

  // generous bound: the whole sequence runs well under 2000 of the 20000 cycles allowed
  initial begin
    #200000;
    fails++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h81D2B1D1));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(link_ready, 1'b0);
    chk(clr_out, 1'b1);
    chk(bclk_oe, 1'b1);
    n = 0;
    while (link_ready !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk(n >= slsp_pkg::RESET_SEQ_CYC && n < 300, 1'b1);
    chk(clr_out, 1'b0);
    $display("test reset done");
    // a write to an unmapped place must not show anywhere
    wb(1'b1, 8'h10, 32'hFF, rd);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, adr_t[i], 32'h0, rd);
      chk(rd, val_t[i]);
    end
    wb(1'b0, slsp_pkg::ADR_STATUS, 32'h0, rd);
    chk(rd[1:0], 2'b01);
    wb(1'b1, slsp_pkg::ADR_GAP, 32'h03, rd);
    wb(1'b0, slsp_pkg::ADR_GAP, 32'h0, rd);
    chk(rd, 32'h03);
    $display("test registers done");
    // a first burst has no earlier end, so there is no gap to judge
    s = rises[3];
    n = rises[0];
    slsp_user_model_i.stream(3, 4, 3);
    chk(rises[3] - s, 0);
    s = rises[3];
    slsp_user_model_i.stream(3, 4, 2);
    repeat (30) @(posedge clk);
    chk(rises[3] - s, 2);
    chk(rises[0] - n, 0);
    chk(exp_q.size(), 0);
    $display("test stream done");
    for (int en = 0; en < 2; en++) begin
      wb(1'b1, slsp_pkg::ADR_CTRL, {28'h0, en[0], 3'b010}, rd);
      n = crc_seen;
      crc_force <= 1'b1;
      repeat (2) @(posedge clk);
      crc_force <= 1'b0;
      slsp_user_model_i.stream(1, 3, 2);
      repeat (20) @(posedge clk);
      chk(crc_seen - n, en);
    end
    $display("test checksum fault done");
    // slow drain so the buffer fills and refuses
    wb(1'b1, slsp_pkg::ADR_DRAIN, 32'hFF, rd);
    n = rises[0];
    chk_on <= 1'b0;
    slsp_user_model_i.stream(1, 24, 2);
    chk(rises[0] > n, 1'b1);
    wb(1'b1, slsp_pkg::ADR_DRAIN, 32'h01, rd);
    repeat (200) @(posedge clk);
    exp_q.delete();
    chk_on <= 1'b1;
    slsp_user_model_i.stream(1, 4, 2);
    repeat (30) @(posedge clk);
    chk(exp_q.size(), 0);
    $display("test overflow done");
    // continuous mode: one long burst, optional end marker, no gap check
    wb(1'b1, slsp_pkg::ADR_CTRL, 32'h0, rd);
    s = rises[3];
    slsp_user_model_i.stream(1, 8, 2);
    repeat (30) @(posedge clk);
    chk(exp_q.size(), 0);
    chk(rises[3] - s, 0);
    $display("test continuous done");
    // upset in one copy is outvoted, in both only reported;
    // bit 75 is data bit 0 of the upper copy with one lane
    wb(1'b1, slsp_pkg::ADR_CTRL, 32'h6, rd);
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, slsp_pkg::ADR_DRAIN, 32'hFF, rd);
      chk_on <= (k == 0);
      slsp_user_model_i.stream(1, 3, 2);
      for (int i = 0; i < 16; i++) begin
        slsp_source_port_i.u_store.mem[i][75] ^= 1'b1;
        if (k == 1) slsp_source_port_i.u_store.mem[i][0] ^= 1'b1;
      end
      n = rises[1 + k];
      wb(1'b1, slsp_pkg::ADR_DRAIN, 32'h01, rd);
      repeat (30) @(posedge clk);
      chk(rises[1 + k] > n, 1'b1);
    end
    chk(exp_q.size(), 0);
    $display("test upset done");
    // advanced mode: the user's domain clear empties the buffer
    wb(1'b1, slsp_pkg::ADR_CTRL, 32'h2, rd);
    wb(1'b1, slsp_pkg::ADR_DRAIN, 32'hFF, rd);
    slsp_user_model_i.stream(1, 3, 2);
    wb(1'b0, slsp_pkg::ADR_STATUS, 32'h0, rd);
    chk(rd[15:8], 8'h03);
    wb(1'b1, slsp_pkg::ADR_CTRL, 32'h3, rd);
    chk(bclk_oe, 1'b0);
    clr_in <= 1'b1;
    repeat (8) @(posedge clk);
    chk(link_ready, 1'b0);
    wb(1'b0, slsp_pkg::ADR_STATUS, 32'h0, rd);
    chk(rd[15:8], 8'h00);
    clr_in <= 1'b0;
    repeat (8) @(posedge clk);
    chk(link_ready, 1'b1);
    $display("test advanced clear done");
    end_sim();
  end
endmodule // slsp_source_port_bench
